// ===== shared/disc_pkg.sv
// Constants, types and register map of the paired-channel discrepancy checker
package disc_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MS_NS          = 1000000;
  localparam int MS_TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Self-test duration, counted in millisecond ticks
  localparam int SELFTEST_S  = 3;
  localparam int SELFTEST_MS = SELFTEST_S * 1000;
  localparam int SELFTEST_W  = 12;

  // Discrepancy time window, in milliseconds
  localparam int              DT_W         = 12;
  localparam logic [DT_W-1:0] DTIME_MIN_MS = 12'h064;
  localparam logic [DT_W-1:0] DTIME_MAX_MS = 12'h9C4;
  localparam logic [DT_W-1:0] DTIME_STEP_MS = 12'h00A;
  localparam logic [DT_W-1:0] DTIME_DEF_MS = 12'h064;

  // Wishbone register map (byte addresses)
  localparam int             ADDR_W        = 8;
  localparam logic [7:0]     ADDR_CTRL     = 8'h00;
  localparam logic [7:0]     ADDR_DTIME    = 8'h04;
  localparam logic [7:0]     ADDR_STATUS   = 8'h08;
  localparam logic [7:0]     ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0]     ADDR_IRQ_MASK = 8'h10;

  // CTRL fields
  localparam int CTRL_PAIRED_BIT = 0;
  localparam int CTRL_SUPP_LSB   = 1;
  localparam int CTRL_SUPP_MSB   = 2;
  localparam logic CTRL_PAIRED_RST = 1'b1;

  // STATUS fields
  localparam int STAT_CH1_BIT      = 0;
  localparam int STAT_CH2_BIT      = 1;
  localparam int STAT_SAFE_BIT     = 2;
  localparam int STAT_RUN_BIT      = 3;
  localparam int STAT_FAULT_BIT    = 4;
  localparam int STAT_SELFTEST_BIT = 5;

  // Interrupt status / mask layout
  localparam int         IRQ_W            = 1;
  localparam int         IRQ_DISC_ERR_BIT = 0;
  localparam logic [0:0] IRQ_MASK_RST     = 1'h0;

  // Status LEDs
  localparam int NUM_MONO_LEDS    = 3;
  localparam int NUM_BICOLOR_LEDS = 2;

  typedef enum logic [1:0] {
    SUPP_NONE     = 2'b00,
    SUPP_CH1_ZERO = 2'b01,
    SUPP_CH2_ZERO = 2'b10
  } supp_e;

  typedef enum logic [1:0] {
    ST_AGREE  = 2'b00,
    ST_TIMING = 2'b01,
    ST_FAULT  = 2'b10
  } disc_state_e;

  // Mismatch pattern that starts discrepancy timing for a given suppression mode
  function automatic logic trig_pattern(input logic [1:0] supp, input logic a, input logic b);
    logic r;
    r = 1'b0;
    case (supp)
      SUPP_CH1_ZERO: r = a & ~b;
      SUPP_CH2_ZERO: r = b & ~a;
      default:       r = a ^ b;
    endcase
    return r;
  endfunction

endpackage

// ===== shared/disc_if.sv
// Signals between the register/LED shell and the discrepancy evaluator
`timescale 1ns/10ps
`default_nettype none
interface disc_if;
  import disc_pkg::*;
  logic            ch1;
  logic            ch2;
  logic            tick;
  logic            paired;
  logic [1:0]      supp;
  logic [DT_W-1:0] dtime_ms;
  logic            safe;
  logic            running;
  logic            fault;
  logic            err_pulse;

  modport eval (
    input  ch1, ch2, tick, paired, supp, dtime_ms,
    output safe, running, fault, err_pulse
  );
  modport ctl (
    output ch1, ch2, tick, paired, supp, dtime_ms,
    input  safe, running, fault, err_pulse
  );
endinterface
`default_nettype wire

// ===== verilog/disc_eval.sv
// Discrepancy evaluator for one channel pair
`timescale 1ns/10ps
`default_nettype none
module disc_eval
  import disc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  disc_if.eval      dif
);

  disc_state_e     state_ff;
  logic [DT_W-1:0] cnt_ff;
  logic            safe_ff;
  logic            err_ff;
  logic            trig;
  logic            expire;

  assign trig   = trig_pattern(dif.supp, dif.ch1, dif.ch2);
  assign expire = (cnt_ff + 12'h001) >= dif.dtime_ms;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_AGREE;
      cnt_ff   <= '0;
      safe_ff  <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      err_ff <= 1'b0;
      if (!dif.paired) begin
        // Timing settings only matter in paired mode; single mode is a plain AND
        state_ff <= ST_AGREE;
        cnt_ff   <= '0;
        safe_ff  <= dif.ch1 & dif.ch2;
      end else begin
        unique case (state_ff)
          ST_AGREE: begin
            if (trig) begin
              state_ff <= ST_TIMING;
              cnt_ff   <= '0;
              safe_ff  <= 1'b0;
            end else begin
              // A suppressed mismatch still yields 0 here, never a stale 1
              safe_ff <= dif.ch1 & dif.ch2;
            end
          end
          ST_TIMING: begin
            if (dif.ch1 == dif.ch2) begin
              state_ff <= ST_AGREE;
              safe_ff  <= dif.ch1;
            end else if (dif.tick) begin
              if (expire) begin
                state_ff <= ST_FAULT;
                err_ff   <= 1'b1;
              end else begin
                cnt_ff <= cnt_ff + 12'h001;
              end
            end
          end
          ST_FAULT: begin
            safe_ff <= 1'b0;
            if (!dif.ch1 && !dif.ch2) begin
              state_ff <= ST_AGREE;
            end
          end
          default: begin
            state_ff <= ST_AGREE;
            safe_ff  <= 1'b0;
          end
        endcase
      end
    end
  end

  assign dif.safe      = safe_ff;
  assign dif.running   = (state_ff == ST_TIMING);
  assign dif.fault     = (state_ff == ST_FAULT);
  assign dif.err_pulse = err_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_unpaired_idle: assert property (!dif.paired |=> state_ff == ST_AGREE && !err_ff)
    else $error("evaluator left idle while not paired");
  a_disc_start: assert property (dif.paired && state_ff == ST_AGREE && trig
                                 |=> state_ff == ST_TIMING && !safe_ff)
    else $error("discrepancy timing did not start");
  a_supp_ch1: assert property (dif.paired && state_ff == ST_AGREE && dif.supp == SUPP_CH1_ZERO
                               && !dif.ch1 && dif.ch2 |=> state_ff == ST_AGREE)
    else $error("suppressed channel 1 zero started timing");
  a_supp_ch2: assert property (dif.paired && state_ff == ST_AGREE && dif.supp == SUPP_CH2_ZERO
                               && dif.ch1 && !dif.ch2 |=> state_ff == ST_AGREE)
    else $error("suppressed channel 2 zero started timing");
  a_safe_running: assert property (state_ff == ST_TIMING |-> !safe_ff)
    else $error("safe value not 0 while timing");
  a_err_expiry: assert property (dif.paired && state_ff == ST_TIMING && dif.ch1 != dif.ch2
                                 && dif.tick && expire
                                 |=> err_ff && state_ff == ST_FAULT ##1 !err_ff)
    else $error("no single error pulse on expiry");
  a_fault_hold: assert property (dif.paired && state_ff == ST_FAULT && (dif.ch1 || dif.ch2)
                                 |=> state_ff == ST_FAULT && !safe_ff)
    else $error("fault released before both channels were 0");
  a_single_and: assert property (!dif.paired |=> safe_ff == $past(dif.ch1 & dif.ch2))
    else $error("single mode output is not the AND of both inputs");
  a_agree_stop: assert property (dif.paired && state_ff == ST_TIMING && dif.ch1 == dif.ch2
                                 |=> state_ff == ST_AGREE && !err_ff
                                 && safe_ff == $past(dif.ch1))
    else $error("agreement did not stop timer cleanly");

  c_timing_agree: cover property (state_ff == ST_TIMING ##1 state_ff == ST_AGREE);
  c_fault: cover property (err_ff);
  c_fault_clear: cover property (state_ff == ST_FAULT ##1 state_ff == ST_AGREE);

endmodule
`default_nettype wire

// ===== verilog/disc_check.sv
// Paired-channel discrepancy checker with Wishbone registers, interrupt and LEDs
//
// Summary of operation
// - Suppression mode and discrepancy time act only when the pair is set to paired evaluation.
// - After reset the suppression mode is "no suppression".
// - Without suppression, timing starts as soon as the two sampled channels differ either way.
// - With channel 1 zero suppressed, timing starts only for channel 1 high and channel 2 low.
// - With channel 2 zero suppressed, timing starts only for channel 2 high and channel 1 low.
// - While timing runs the safe input reported to the controller is 0.
// - A mismatch still present when the time expires sets a discrepancy error and an interrupt.
// - Discrepancy time accepts 100 ms to 2500 ms in 10 ms steps, default 100 ms.
// - After the first startup every status LED is lit for 3 s, two-colour LEDs yellow.
// - After a discrepancy error the input stays 0 until both channels have been seen at 0.
// - In single evaluation an ON result is forwarded only while both inputs are ON.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module disc_check
  import disc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [ADDR_W-1:0]           wb_adr_i,
  input  wire logic [31:0]                 wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic                        wb_we_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        ch1_i,
  input  wire logic                        ch2_i,
  output logic                             safe_in_o,
  output logic                             irq_o,
  output logic      [NUM_MONO_LEDS-1:0]    led_mono_o,
  output logic      [NUM_BICOLOR_LEDS-1:0] led_red_o,
  output logic      [NUM_BICOLOR_LEDS-1:0] led_green_o
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  disc_if dif ();

  // Input synchronisers; both channels move through the same stages together
  logic [1:0]            meta_ff;
  logic [1:0]            sync_ff;
  // Time base
  logic [TICK_W-1:0]     tdiv_ff;
  logic                  tick_ff;
  // Registers
  logic                  paired_ff;
  logic [1:0]            supp_ff;
  logic [DT_W-1:0]       dtime_ff;
  logic [IRQ_W-1:0]      irq_stat_ff;
  logic [IRQ_W-1:0]      irq_mask_ff;
  logic                  ack_ff;
  logic [31:0]           rdata_ff;
  // Self-test
  logic                  selftest_ff;
  logic [SELFTEST_W-1:0] st_cnt_ff;
  // Registered outputs
  logic                  safe_ff;
  logic                  irq_ff;
  logic [NUM_MONO_LEDS-1:0]    mono_ff;
  logic [NUM_BICOLOR_LEDS-1:0] red_ff;
  logic [NUM_BICOLOR_LEDS-1:0] green_ff;

  logic                  wb_req;
  logic                  wr_en;
  logic [DT_W-1:0]       wr_dtime;
  logic                  dtime_ok;
  logic [31:0]           nxt_rdata;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
    end else begin
      meta_ff <= {ch2_i, ch1_i};
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdiv_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tdiv_ff == TICK_W'(TICK_CYCLES - 1)) begin
      tdiv_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tdiv_ff <= tdiv_ff + TICK_W'(1);
      tick_ff <= 1'b0;
    end
  end

  assign dif.ch1      = sync_ff[0];
  assign dif.ch2      = sync_ff[1];
  assign dif.tick     = tick_ff;
  assign dif.paired   = paired_ff;
  assign dif.supp     = supp_ff;
  assign dif.dtime_ms = dtime_ff;

  disc_eval u_eval (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dif   (dif)
  );

  // Wishbone classic slave: one wait state, writes land on the request's first edge
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_en    = wb_req & wb_we_i;
  assign wr_dtime = wb_dat_i[DT_W-1:0];
  // Out-of-range or off-step values are dropped so the window is always legal
  assign dtime_ok = (wr_dtime >= DTIME_MIN_MS) && (wr_dtime <= DTIME_MAX_MS)
                    && ((wr_dtime % DTIME_STEP_MS) == 12'h000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      paired_ff <= CTRL_PAIRED_RST;
      supp_ff   <= SUPP_NONE;
    end else if (wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      paired_ff <= wb_dat_i[CTRL_PAIRED_BIT];
      supp_ff   <= wb_dat_i[CTRL_SUPP_MSB:CTRL_SUPP_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtime_ff <= DTIME_DEF_MS;
    end else if (wr_en && wb_adr_i == ADDR_DTIME && (&wb_sel_i[1:0]) && dtime_ok) begin
      dtime_ff <= wr_dtime;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wr_en && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Sticky status: a new error in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      if (wr_en && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_ff <= irq_stat_ff & ~wb_dat_i[IRQ_W-1:0];
      end
      if (dif.err_pulse) begin
        irq_stat_ff[IRQ_DISC_ERR_BIT] <= 1'b1;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_CTRL: begin
        nxt_rdata[CTRL_PAIRED_BIT]               = paired_ff;
        nxt_rdata[CTRL_SUPP_MSB:CTRL_SUPP_LSB]   = supp_ff;
      end
      ADDR_DTIME: begin
        nxt_rdata[DT_W-1:0] = dtime_ff;
      end
      ADDR_STATUS: begin
        nxt_rdata[STAT_CH1_BIT]      = sync_ff[0];
        nxt_rdata[STAT_CH2_BIT]      = sync_ff[1];
        nxt_rdata[STAT_SAFE_BIT]     = safe_ff;
        nxt_rdata[STAT_RUN_BIT]      = dif.running;
        nxt_rdata[STAT_FAULT_BIT]    = dif.fault;
        nxt_rdata[STAT_SELFTEST_BIT] = selftest_ff;
      end
      ADDR_IRQ_STAT: begin
        nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      end
      ADDR_IRQ_MASK: begin
        nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (wb_req) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Self-test runs once after reset; it does not delay evaluation of the inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selftest_ff <= 1'b1;
      st_cnt_ff   <= '0;
    end else if (selftest_ff && tick_ff) begin
      if (st_cnt_ff == SELFTEST_W'(SELFTEST_MS - 1)) begin
        selftest_ff <= 1'b0;
      end else begin
        st_cnt_ff <= st_cnt_ff + SELFTEST_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      safe_ff  <= 1'b0;
      irq_ff   <= 1'b0;
      mono_ff  <= '0;
      red_ff   <= '0;
      green_ff <= '0;
    end else begin
      safe_ff <= dif.safe;
      irq_ff  <= |(irq_stat_ff & irq_mask_ff);
      if (selftest_ff) begin
        mono_ff  <= '1;
        red_ff   <= '1;
        green_ff <= '1;
      end else begin
        mono_ff  <= {dif.fault, dif.running, dif.safe};
        red_ff   <= {|irq_stat_ff, dif.fault};
        green_ff <= {~|irq_stat_ff, ~dif.fault};
      end
    end
  end

  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = rdata_ff;
  assign safe_in_o   = safe_ff;
  assign irq_o       = irq_ff;
  assign led_mono_o  = mono_ff;
  assign led_red_o   = red_ff;
  assign led_green_o = green_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_supp_default: assert property ($past(rst_i) |-> supp_ff == SUPP_NONE
                                   && dtime_ff == DTIME_DEF_MS)
    else $error("reset defaults not in place");
  a_dtime_range: assert property (dtime_ff >= DTIME_MIN_MS && dtime_ff <= DTIME_MAX_MS
                                  && (dtime_ff % DTIME_STEP_MS) == 12'h000)
    else $error("discrepancy time outside legal range");
  a_selftest_leds: assert property (selftest_ff |=> (&led_mono_o) && (&led_red_o)
                                    && (&led_green_o))
    else $error("LEDs not all lit during self-test");
  a_tick_pulse: assert property (tick_ff |=> !tick_ff [*2])
    else $error("millisecond tick wider than one cycle");
  a_err_sticky: assert property (dif.err_pulse |=> irq_stat_ff[IRQ_DISC_ERR_BIT]
                                 ##1 (irq_o == irq_mask_ff[IRQ_DISC_ERR_BIT]))
    else $error("discrepancy error not latched into interrupt");
  a_safe_follow: assert property (safe_in_o == $past(dif.safe))
    else $error("safe output does not follow evaluator");

  c_selftest_end: cover property ($fell(selftest_ff));
  c_irq: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// ===== tb/sensor_pair.sv
// Two-channel sensor model: one channel leads, the other trails it by a set lag
`timescale 1ns/10ps
`default_nettype none
module sensor_pair (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        want_i,
  input  wire logic [11:0] lag_i,
  input  wire logic        ch1_leads_i,
  output logic             ch1_o,
  output logic             ch2_o
);
  logic        lead_ff;
  logic        follow_ff;
  logic [11:0] cnt_ff;

  // Real contacts never close together, so the follower lags by lag_i cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lead_ff <= 1'b0;
      follow_ff <= 1'b0;
      cnt_ff <= 12'h000;
    end else begin
      lead_ff <= want_i;
      if (follow_ff == want_i) begin
        cnt_ff <= 12'h000;
      end else if (cnt_ff >= lag_i) begin
        follow_ff <= want_i;
        cnt_ff <= 12'h000;
      end else begin
        cnt_ff <= cnt_ff + 12'h001;
      end
    end
  end

  assign ch1_o = ch1_leads_i ? lead_ff : follow_ff;
  assign ch2_o = ch1_leads_i ? follow_ff : lead_ff;
endmodule
`default_nettype wire

// ===== tb/tb_disc_check.sv
// Self-checking bench for the paired-channel discrepancy checker
`timescale 1ns/10ps
`default_nettype none
module tb_disc_check;
  import disc_pkg::*;
  localparam int TK = 10;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_we = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        ch1;
  logic        ch2;
  logic        safe;
  logic        irq;
  logic [2:0]  led_mono;
  logic [1:0]  led_red;
  logic [1:0]  led_green;
  logic        want = 1'b0;
  logic [11:0] lag = 12'h000;
  logic        lead1 = 1'b1;
  logic [31:0] rd;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc_n = 0;
  integer      seed = 455;

  always #20 clk_i = ~clk_i;

  disc_check #(.TICK_CYCLES(TK)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .ch1_i(ch1), .ch2_i(ch2), .safe_in_o(safe), .irq_o(irq),
    .led_mono_o(led_mono), .led_red_o(led_red), .led_green_o(led_green)
  );

  sensor_pair sensor (
    .clk_i(clk_i), .rst_i(rst_i), .want_i(want), .lag_i(lag), .ch1_leads_i(lead1),
    .ch1_o(ch1), .ch2_o(ch2)
  );

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  // One classic cycle; read data lands in rd at the edge that sees ack
  // No local limit on the wait; a slave that never answers is caught by the cycle ceiling
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic sense(input logic w, input logic [11:0] lg, input logic l1, input int n);
    @(posedge clk_i);
    want <= w;
    lag <= lg;
    lead1 <= l1;
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic exp_trig(input logic [1:0] s, input logic a, input logic b);
    if (s == 2'b01) return a & ~b;
    if (s == 2'b10) return b & ~a;
    return a ^ b;
  endfunction

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    int          m;
    int          i;
    logic        w;
    logic [11:0] lg;
    int          bad [3] = '{99, 2510, 105};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_word("self-test leds", 32'h7F, {25'h0, led_mono, led_red, led_green});
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk_word("ctrl reset", 32'h1, rd);
    wb(1'b0, ADDR_DTIME, 32'h0);
    chk_word("dtime reset", 32'h64, rd);
    wb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk_word("mask reset", 32'h0, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk_word("unmapped read", 32'h0, rd);
    test_end("reset");
    for (i = 0; i < 3; i++) begin
      wb(1'b1, ADDR_DTIME, 32'(bad[i]));
      wb(1'b0, ADDR_DTIME, 32'h0);
      chk_word("dtime kept", 32'h64, rd);
    end
    wb(1'b1, ADDR_DTIME, 32'h9C4);
    wb(1'b0, ADDR_DTIME, 32'h0);
    chk_word("dtime max", 32'h9C4, rd);
    wb(1'b1, ADDR_DTIME, 32'h64);
    test_end("dtime");
    for (m = 0; m < 4; m++) begin
      wb(1'b1, ADDR_CTRL, 32'(m * 2 + 1));
      for (i = 0; i < 2; i++) begin
        sense(1'b1, 12'hFFF, i == 0, 20);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk_bit("running", exp_trig(m[1:0], i == 0, i == 1), rd[STAT_RUN_BIT]);
        chk_bit("safe in mismatch", 1'b0, safe);
        sense(1'b0, 12'h000, 1'b1, 20);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk_bit("running after agree", 1'b0, rd[STAT_RUN_BIT]);
      end
    end
    test_end("modes");
    wb(1'b1, ADDR_CTRL, 32'h1);
    sense(1'b1, 12'h12C, 1'b1, 100);
    chk_bit("safe while timing", 1'b0, safe);
    repeat (230) @(posedge clk_i);
    chk_bit("safe after agree", 1'b1, safe);
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk_word("no error", 32'h0, rd);
    sense(1'b0, 12'h000, 1'b1, 20);
    test_end("agree");
    wb(1'b1, ADDR_IRQ_MASK, 32'h1);
    sense(1'b1, 12'hFFF, 1'b0, 980);
    chk_bit("irq before window", 1'b0, irq);
    repeat (50) @(posedge clk_i);
    chk_bit("irq after window", 1'b1, irq);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk_bit("fault", 1'b1, rd[STAT_FAULT_BIT]);
    sense(1'b1, 12'h000, 1'b0, 20);
    chk_bit("safe held after fault", 1'b0, safe);
    sense(1'b0, 12'h000, 1'b1, 20);
    sense(1'b1, 12'h000, 1'b1, 20);
    chk_bit("safe after both low", 1'b1, safe);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk_bit("irq masked", 1'b0, irq);
    wb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk_i);
    chk_bit("irq unmasked", 1'b1, irq);
    wb(1'b1, ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk_i);
    chk_bit("irq cleared", 1'b0, irq);
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk_word("stat cleared", 32'h0, rd);
    test_end("expiry");
    wb(1'b1, ADDR_CTRL, 32'h0);
    sense(1'b0, 12'h000, 1'b1, 20);
    sense(1'b1, 12'hFFF, 1'b1, 1100);
    chk_bit("no irq in single", 1'b0, irq);
    chk_bit("single mismatch", 1'b0, safe);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk_bit("no timing in single", 1'b0, rd[STAT_RUN_BIT]);
    sense(1'b0, 12'h000, 1'b1, 20);
    test_end("single");
    // Paired lags stay under the 100 ms window, so no error may appear
    for (m = 0; m < 2; m++) begin
      wb(1'b1, ADDR_CTRL, 32'(m));
      for (i = 0; i < 12; i++) begin
        w = 1'($random(seed));
        lg = 12'($random(seed)) & ((m == 1) ? 12'h1FF : 12'h01F);
        sense(w, lg, 1'($random(seed)), int'(lg) + 10);
        chk_bit("safe settled", w, safe);
      end
    end
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk_word("no error after skew", 32'h0, rd);
    test_end("random");
    while (cyc_n < 30100) @(posedge clk_i);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk_bit("self-test over", 1'b0, rd[STAT_SELFTEST_BIT]);
    chk_word("red leds idle", 32'h0, {30'h0, led_red});
    chk_word("green leds idle", 32'h3, {30'h0, led_green});
    // After the lit phase the mono LEDs show fault, running and the last settled value
    chk_word("mono leds idle", {29'h0, 2'h0, w}, {29'h0, led_mono});
    test_end("self-test");
    stop_test();
  end
endmodule
`default_nettype wire
